// ===== verilog/css_top.sv
// Clock source selection, start-up delays and clock domain gating with APB access
//
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
`include "css_cfg.svh"
module css_top #(
    parameter int unsigned WDT_SHORT_CK = 4096,
    parameter int unsigned WDT_LONG_CK = 65536,
    parameter int unsigned XTAL_LONG_CK = 16384,
    parameter int unsigned LF_LONG_CK = 32768
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] clock_source_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic divide_by_eight_fuse,
    input wire logic oscillator_input_pin,
    input wire logic lf_crystal_pin,
    input wire logic rc_oscillator_tick,
    input wire logic watchdog_oscillator,
    input wire logic wake_event,
    output logic oscillator_output_pin,
    output logic core_clock_en,
    output logic peripheral_clock_en,
    output logic flash_interface_clock_en,
    output logic async_timer_clock_en,
    output logic converter_clock_en,
    output logic [3:0] prescale_select
);
    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        css_pkg::css_state_e st;
        logic [1:0] fuse_wait;
        logic [3:0] cksel;
        logic [1:0] sut;
        logic div8;
        css_pkg::css_sleep_e mode;
        css_pkg::css_sleep_e sleep_mode;
        logic async_en;
        logic [3:0] presc;
        logic [31:0] rdata;
        logic cnt_start;
        logic [16:0] cnt_target;
        logic cnt_wdt;
        logic core_en;
        logic io_en;
        logic asy_en;
        logic adc_en;
    } css_top_s;
    css_top_s q, next_q;

    // ----------------------------------------
    // Pin synchronisers and delay counter
    // ----------------------------------------
    logic [8:0] pin_raw;
    logic [8:0] pin_lvl;
    logic [8:0] pin_rise;
    logic src_tick;
    logic wdt_tick;
    logic wake_rise;
    logic [3:0] fuse_cksel_s;
    logic [1:0] fuse_sut_s;
    logic fuse_div8_s;
    css_pkg::css_source_e src;

    assign pin_raw = {divide_by_eight_fuse, startup_time_fuses, clock_source_select_fuses[3:0],
                      wake_event, watchdog_oscillator};
    css_sync #(.W(9)) u_sync_ctl (
        .pclk(pclk),
        .presetn(presetn),
        .pin(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise)
    );

    logic [2:0] src_lvl;
    logic [2:0] src_rise;
    css_sync #(.W(3)) u_sync_src (
        .pclk(pclk),
        .presetn(presetn),
        .pin({rc_oscillator_tick, lf_crystal_pin, oscillator_input_pin}),
        .level(src_lvl),
        .rise(src_rise)
    );

    // Fuse levels and event edges after synchronisation
    assign fuse_cksel_s = pin_lvl[5:2];
    assign fuse_sut_s = pin_lvl[7:6];
    assign fuse_div8_s = pin_lvl[8];
    assign wdt_tick = pin_rise[0];
    assign wake_rise = pin_rise[1];

    css_cnt_if cif ();
    css_delay u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif)
    );

    // ----------------------------------------
    // Fuse decoding
    // ----------------------------------------
    // Codes are compared as stored, so a programmed bit reads 0
    function automatic css_pkg::css_source_e decode_src(input logic [3:0] ck);
        if (ck[3]) begin
            decode_src = css_pkg::SRC_XTAL;
        end else if (ck[3:1] == 3'h3) begin
            decode_src = css_pkg::SRC_LF;
        end else if (ck == `CSS_CKSEL_RC) begin
            decode_src = css_pkg::SRC_RC;
        end else if (ck == `CSS_CKSEL_EXT) begin
            decode_src = css_pkg::SRC_EXT;
        end else begin
            decode_src = css_pkg::SRC_RSVD;
        end
    endfunction

    // Source cycles to wait on wake from the deep sleep modes
    function automatic logic [16:0] wake_count(input css_pkg::css_source_e s,
                                               input logic b0, input logic [1:0] su);
        wake_count = `CSS_WAKE_RC;
        if (s == css_pkg::SRC_XTAL) begin
            if (!b0 && !su[1]) begin
                wake_count = `CSS_WAKE_SHORT;
            end else if (!b0 || su == 2'h0) begin
                wake_count = `CSS_WAKE_MID;
            end else begin
                wake_count = XTAL_LONG_CK[16:0];
            end
        end else if (s == css_pkg::SRC_LF) begin
            wake_count = b0 ? LF_LONG_CK[16:0] : `CSS_WAKE_MID;
        end
    endfunction

    // Watchdog cycles of the reset time-out
    function automatic logic [16:0] wdt_count(input css_pkg::css_source_e s,
                                              input logic b0, input logic [1:0] su);
        logic [1:0] sel;
        sel = su;
        if (s == css_pkg::SRC_XTAL) begin
            unique case ({b0, su})
                3'h0, 3'h3, 3'h6: sel = 2'h1;
                3'h1, 3'h4, 3'h7: sel = 2'h2;
                default: sel = 2'h0;
            endcase
        end
        unique case (sel)
            2'h0: wdt_count = 17'h00000;
            2'h1: wdt_count = WDT_SHORT_CK[16:0];
            default: wdt_count = WDT_LONG_CK[16:0];
        endcase
    endfunction

    assign src = decode_src(q.cksel);

    // Selected source edge counts the source-cycle delays
    always_comb begin
        unique case (src)
            css_pkg::SRC_LF: src_tick = src_rise[1];
            css_pkg::SRC_RC: src_tick = src_rise[2];
            default: src_tick = src_rise[0];
        endcase
    end

    assign cif.start = q.cnt_start;
    assign cif.target = q.cnt_target;
    assign cif.tick = q.cnt_wdt ? wdt_tick : src_tick;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic setup;
    logic wr_acc;
    logic hit;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign hit = (paddr == `CSS_OFF_CTRL) || (paddr == `CSS_OFF_PRESC) ||
                 (paddr == `CSS_OFF_STATUS) || (paddr == `CSS_OFF_RANGE);

    // ----------------------------------------
    // Sequencer, registers and clock gates
    // ----------------------------------------
    always_comb begin
        next_q = q;
        next_q.cnt_start = 1'b0;
        // Read data is prepared in the setup cycle
        if (setup) begin
            unique case (paddr)
                `CSS_OFF_CTRL: next_q.rdata = {27'h0, q.async_en, 1'b0, q.mode};
                `CSS_OFF_PRESC: next_q.rdata = {28'h0, q.presc};
                `CSS_OFF_STATUS: next_q.rdata = {16'h0, q.st, src, q.div8,
                                                 q.sut, q.cksel};
                `CSS_OFF_RANGE: next_q.rdata = {29'h0, q.cksel[3:1]};
                default: next_q.rdata = 32'h00000000;
            endcase
        end
        // Register writes; the sleep request is honoured only while running
        if (wr_acc && paddr == `CSS_OFF_CTRL) begin
            next_q.mode = css_pkg::css_sleep_e'(pwdata[`CSS_CTRL_MODE_LSB +: 3]);
            next_q.async_en = pwdata[`CSS_CTRL_ASY_BIT];
        end
        if (wr_acc && paddr == `CSS_OFF_PRESC) begin
            next_q.presc = pwdata[3:0];
        end
        unique case (q.st)
            // Fuse levels are taken once the synchroniser has settled
            css_pkg::ST_FUSE: begin
                next_q.fuse_wait = q.fuse_wait + 2'h1;
                if (q.fuse_wait == `CSS_FUSE_WAIT) begin
                    next_q.cksel = fuse_cksel_s;
                    next_q.sut = fuse_sut_s;
                    next_q.div8 = fuse_div8_s;
                    next_q.presc = fuse_div8_s ? `CSS_PRESC_DIV1 : `CSS_PRESC_DIV8;
                    next_q.st = css_pkg::ST_RST_CK;
                    next_q.cnt_start = 1'b1;
                    next_q.cnt_wdt = 1'b0;
                    next_q.cnt_target = (decode_src(fuse_cksel_s) == css_pkg::SRC_LF) ?
                                        `CSS_LF_RST_CK : `CSS_RST_CK;
                end
            end
            // Fixed source cycles after reset, then the watchdog time-out
            css_pkg::ST_RST_CK: begin
                if (!q.cnt_start && cif.done) begin
                    next_q.st = css_pkg::ST_RST_WDT;
                    next_q.cnt_start = 1'b1;
                    next_q.cnt_wdt = 1'b1;
                    next_q.cnt_target = wdt_count(src, q.cksel[0], q.sut);
                end
            end
            css_pkg::ST_RST_WDT: begin
                if (!q.cnt_start && cif.done) begin
                    next_q.st = css_pkg::ST_RUN;
                end
            end
            // Software asks for sleep with the go bit
            css_pkg::ST_RUN: begin
                if (wr_acc && paddr == `CSS_OFF_CTRL && pwdata[`CSS_CTRL_GO_BIT]) begin
                    next_q.st = css_pkg::ST_SLEEP;
                    next_q.sleep_mode = css_pkg::css_sleep_e'(pwdata[2:0]);
                end
            end
            // Wake events come through a synchroniser on the free-running clock
            css_pkg::ST_SLEEP: begin
                if (wake_rise) begin
                    if (q.sleep_mode == css_pkg::SLP_PDOWN ||
                        q.sleep_mode == css_pkg::SLP_PSAVE ||
                        q.sleep_mode == css_pkg::SLP_STBY) begin
                        next_q.st = css_pkg::ST_WAKE;
                        next_q.cnt_start = 1'b1;
                        next_q.cnt_wdt = 1'b0;
                        next_q.cnt_target = wake_count(src, q.cksel[0], q.sut);
                    end else begin
                        next_q.st = css_pkg::ST_RUN;
                    end
                end
            end
            // Selected source times the oscillator settling before execution
            css_pkg::ST_WAKE: begin
                if (!q.cnt_start && cif.done) begin
                    next_q.st = css_pkg::ST_RUN;
                end
            end
        endcase
        // Gates follow the state being entered
        next_q.core_en = (next_q.st == css_pkg::ST_RUN);
        next_q.io_en = next_q.core_en;
        next_q.adc_en = next_q.core_en;
        next_q.asy_en = q.async_en && (next_q.st == css_pkg::ST_RUN);
        if (next_q.st == css_pkg::ST_SLEEP) begin
            unique case (next_q.sleep_mode)
                css_pkg::SLP_ADC: begin
                    next_q.adc_en = 1'b1;
                    next_q.asy_en = q.async_en;
                end
                css_pkg::SLP_PSAVE: begin
                    next_q.asy_en = q.async_en;
                end
                css_pkg::SLP_PDOWN, css_pkg::SLP_STBY: begin
                    next_q.asy_en = 1'b0;
                end
                default: begin
                    next_q.io_en = 1'b1;
                    next_q.adc_en = 1'b1;
                    next_q.asy_en = q.async_en;
                end
            endcase
        end
    end

    // State register; delivered fuse setting until the pins are sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= css_pkg::ST_FUSE;
            q.cksel <= `CSS_CKSEL_RESET;
            q.sut <= `CSS_SUT_RESET;
            q.div8 <= `CSS_DIV8_RESET;
            q.presc <= `CSS_PRESC_DIV8;
            q.mode <= css_pkg::SLP_IDLE;
            q.sleep_mode <= css_pkg::SLP_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign core_clock_en = q.core_en;
    assign flash_interface_clock_en = q.core_en;
    assign peripheral_clock_en = q.io_en;
    assign async_timer_clock_en = q.asy_en;
    assign converter_clock_en = q.adc_en;
    assign prescale_select = q.presc;
    // Amplifier output drives only when the crystal oscillator is chosen
    assign oscillator_output_pin = (src == css_pkg::SRC_XTAL) && !src_lvl[0];
endmodule
`default_nettype wire

// ===== verilog/css_cfg.svh
// Offsets, field positions, reset values and cycle counts of the clock start-up block
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CSS_OFF_CTRL 12'h000
`define CSS_OFF_PRESC 12'h004
`define CSS_OFF_STATUS 12'h008
`define CSS_OFF_RANGE 12'h00c
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CSS_CTRL_MODE_LSB 0
`define CSS_CTRL_GO_BIT 3
`define CSS_CTRL_ASY_BIT 4
// ----------------------------------------
// Fuse codes as stored (0 = programmed) and prescaler codes
// ----------------------------------------
`define CSS_CKSEL_RC 4'h2
`define CSS_CKSEL_EXT 4'h0
`define CSS_CKSEL_RESET 4'h2
`define CSS_SUT_RESET 2'h2
`define CSS_DIV8_RESET 1'h0
`define CSS_PRESC_DIV8 4'h3
`define CSS_PRESC_DIV1 4'h0
// ----------------------------------------
// Start-up counts in source cycles; the fuse wait in pclk cycles
// ----------------------------------------
`define CSS_RST_CK 17'h0000e
`define CSS_LF_RST_CK 17'h00004
`define CSS_WAKE_SHORT 17'h00102
`define CSS_WAKE_MID 17'h00400
`define CSS_WAKE_RC 17'h00006
`define CSS_FUSE_WAIT 2'h3
`endif

// ===== verilog/css_pkg.sv
// Types shared by the clock start-up block
`default_nettype none
package css_pkg;
    // Start-up sequencer states
    typedef enum logic [5:0] {
        ST_FUSE = 6'h01,
        ST_RST_CK = 6'h02,
        ST_RST_WDT = 6'h04,
        ST_RUN = 6'h08,
        ST_SLEEP = 6'h10,
        ST_WAKE = 6'h20
    } css_state_e;
    // Decoded clock source
    typedef enum logic [2:0] {
        SRC_XTAL = 3'h1,
        SRC_LF = 3'h2,
        SRC_RC = 3'h3,
        SRC_EXT = 3'h4,
        SRC_RSVD = 3'h7
    } css_source_e;
    // Sleep modes as written to the control register
    typedef enum logic [2:0] {
        SLP_IDLE = 3'h0,
        SLP_ADC = 3'h1,
        SLP_PDOWN = 3'h2,
        SLP_PSAVE = 3'h3,
        SLP_STBY = 3'h6
    } css_sleep_e;
endpackage
`default_nettype wire

// ===== verilog/css_cnt_if.sv
// Handshake between the start-up sequencer and its delay counter
`default_nettype none
interface css_cnt_if;
    logic start;
    logic [16:0] target;
    logic tick;
    logic done;
    modport ctrl (output start, output target, output tick, input done);
    modport cnt (input start, input target, input tick, output done);
endinterface
`default_nettype wire

// ===== verilog/css_sync.sv
// Two-stage synchroniser with rising-edge pulses for pin inputs
`default_nettype none
module css_sync #(
    parameter int W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } css_sync_s;
    css_sync_s q, next_q;

    // First stage feeds only the second; edges are seen between stages two and three
    always_comb begin
        next_q = '{s1: pin, s2: q.s1, s3: q.s2};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign level = q.s2;
    assign rise = q.s2 & ~q.s3;
endmodule
`default_nettype wire

// ===== verilog/css_delay.sv
// Counts tick pulses up to a target and then holds done
`default_nettype none
module css_delay (
    input wire logic pclk,
    input wire logic presetn,
    css_cnt_if.cnt cif
);
    typedef struct packed {
        logic [16:0] count;
        logic done;
    } css_delay_s;
    css_delay_s q, next_q;

    // Start clears the count; a zero target is done at once
    always_comb begin
        next_q = q;
        if (cif.start) begin
            next_q.count = 17'h00000;
            next_q.done = (cif.target == 17'h00000);
        end else if (cif.tick && !q.done) begin
            next_q.count = q.count + 17'h00001;
            next_q.done = ((q.count + 17'h00001) >= cif.target);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign cif.done = q.done;
endmodule
`default_nettype wire

// ===== verif/css_top_checker.sv
// Port-level assertions for the clock start-up block
`default_nettype none
module css_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] clock_source_select_fuses,
    input wire logic oscillator_input_pin,
    input wire logic wake_event,
    input wire logic oscillator_output_pin,
    input wire logic core_clock_en,
    input wire logic peripheral_clock_en,
    input wire logic flash_interface_clock_en,
    input wire logic converter_clock_en,
    input wire logic [3:0] prescale_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Gate relations, start-up hold and oscillator output
    property p_flash; flash_interface_clock_en == core_clock_en; endproperty
    a_flash: assert property (p_flash) else $error("flash gate off core gate");
    property p_core; core_clock_en |-> peripheral_clock_en && converter_clock_en; endproperty
    a_core: assert property (p_core) else $error("core on with domain off");
    property p_conv; peripheral_clock_en |-> converter_clock_en; endproperty
    a_conv: assert property (p_conv) else $error("converter off with io on");
    property p_presc; $rose(presetn) |-> prescale_select == 4'h3; endproperty
    a_presc: assert property (p_presc) else $error("prescaler not divide by 8");
    property p_hold; $rose(presetn) |-> !core_clock_en [*8]; endproperty
    a_hold: assert property (p_hold) else $error("core ran too early");
    property p_xoff; !clock_source_select_fuses[3] |-> !oscillator_output_pin; endproperty
    a_xoff: assert property (p_xoff) else $error("amplifier out active");
    property p_xinv;
        core_clock_en && clock_source_select_fuses[3] |->
            oscillator_output_pin == !$past(oscillator_input_pin, 2) ||
            oscillator_output_pin == !$past(oscillator_input_pin, 3);
    endproperty
    a_xinv: assert property (p_xinv) else $error("amplifier out not inverted");
    property p_go;
        psel && penable && pwrite && paddr == 12'h000 && pwdata[3:0] == 4'ha && core_clock_en
            |-> ##[1:2] !core_clock_en && !peripheral_clock_en && !converter_clock_en;
    endproperty
    a_go: assert property (p_go) else $error("deep sleep left gates on");
    c_boot: cover property ($rose(presetn) ##[1:1000] core_clock_en);
    c_sleep: cover property ($fell(core_clock_en));
    c_wake: cover property ($rose(wake_event) ##[1:1000] $rose(core_clock_en));
endmodule
bind css_top css_top_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .clock_source_select_fuses(clock_source_select_fuses),
    .oscillator_input_pin(oscillator_input_pin), .wake_event(wake_event),
    .oscillator_output_pin(oscillator_output_pin), .core_clock_en(core_clock_en),
    .peripheral_clock_en(peripheral_clock_en),
    .flash_interface_clock_en(flash_interface_clock_en),
    .converter_clock_en(converter_clock_en), .prescale_select(prescale_select));
`default_nettype wire

// ===== verif/css_osc_model.sv
// Free-running oscillator sources at the far side of the clock start-up block
`default_nettype none
module css_osc_model #(
    parameter int HOSC = 2,
    parameter int HLF = 3,
    parameter int HRC = 2,
    parameter int HWDT = 5
) (
    input wire logic pclk,
    output logic osc,
    output logic lf,
    output logic rc,
    output logic wdt
);
    timeunit 1ns;
    timeprecision 1ps;
    int t = 0;
    // Square waves, each half period a whole number of system cycles
    always @(posedge pclk) t <= t + 1;
    assign osc = (t / HOSC) % 2 == 1;
    assign lf = (t / HLF) % 2 == 1;
    assign rc = (t / HRC) % 2 == 1;
    assign wdt = (t / HWDT) % 2 == 1;
endmodule
`default_nettype wire

// ===== verif/clock_source_select_startup_bench.sv
// Self-checking bench for the clock start-up block
`default_nettype none
`include "css_cfg.svh"
module clock_source_select_startup_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WS = 4, WL = 16, XL = 8, LL = 12, HO = 2, HL = 3, HR = 2, HW = 5;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic wake = 1'b0;
    logic div8 = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] cksel = 4'h2;
    logic [1:0] sut = 2'h2;
    logic [31:0] prdata;
    logic [3:0] presc;
    logic pready, pslverr, osc, lf, rc, wdt, osc_out, core_en, per_en, fl_en, asy_en, conv_en;
    logic [31:0] lfsr = 32'd79970;
    logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};
    logic [3:0] oth [8] = '{4'h6, 4'h7, 4'h2, 4'h0, 4'h3, 4'h1, 4'h5, 4'h4};
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    css_top #(.WDT_SHORT_CK(WS), .WDT_LONG_CK(WL), .XTAL_LONG_CK(XL), .LF_LONG_CK(LL)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_source_select_fuses(cksel), .startup_time_fuses(sut),
        .divide_by_eight_fuse(div8), .oscillator_input_pin(osc), .lf_crystal_pin(lf),
        .rc_oscillator_tick(rc), .watchdog_oscillator(wdt), .wake_event(wake),
        .oscillator_output_pin(osc_out), .core_clock_en(core_en), .peripheral_clock_en(per_en),
        .flash_interface_clock_en(fl_en), .async_timer_clock_en(asy_en),
        .converter_clock_en(conv_en), .prescale_select(presc));
    css_osc_model #(.HOSC(HO), .HLF(HL), .HRC(HR), .HWDT(HW)) src_u (
        .pclk(pclk), .osc(osc), .lf(lf), .rc(rc), .wdt(wdt));
    // Clock and hang guard
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails++;
            end_sim();
        end
    end
    // Random stream and expectations from the fuse codes and sleep modes
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [2:0] exp_src(input logic [3:0] c);
        if (c[3]) return 3'h1;
        if (c[3:1] == 3'h3) return 3'h2;
        if (c == 4'h2) return 3'h3;
        return (c == 4'h0) ? 3'h4 : 3'h7;
    endfunction
    function automatic int exp_wdt(input logic [3:0] c, input logic [1:0] s);
        if (c[3]) begin
            case ({c[0], s})
                3'h0, 3'h3, 3'h6: return WS;
                3'h1, 3'h4, 3'h7: return WL;
                default: return 0;
            endcase
        end
        return (s == 2'h0) ? 0 : (s == 2'h1) ? WS : WL;
    endfunction
    function automatic int exp_wake(input logic [3:0] c, input logic [1:0] s);
        if (c[3]) return !c[0] ? (s[1] ? 1024 : 258) : (s == 2'h0 ? 1024 : XL);
        if (c[3:1] == 3'h3) return c[0] ? LL : 1024;
        return 6;
    endfunction
    function automatic logic [4:0] exp_gate(input logic [2:0] m, input logic a);
        case (m)
            3'h0: return {4'h3, a};
            3'h1: return {4'h1, a};
            3'h3: return {4'h0, a};
            default: return 5'h00;
        endcase
    endfunction
    // Bus, compare and sequencing tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_core(output int n);
        n = 0;
        while (core_en !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic d);
        int n, w, p, k, lo, hi;
        logic [31:0] r;
        logic e;
        w = exp_wdt(c, s);
        p = (c[3:1] == 3'h3) ? 2 * HL : (c == 4'h2) ? 2 * HR : 2 * HO;
        k = (c[3:1] == 3'h3) ? 4 : 14;
        @(posedge pclk);
        presetn <= 1'b0;
        cksel <= c;
        sut <= s;
        div8 <= d;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_core(n);
        lo = (k - 1) * p + w * 2 * HW - 10;
        hi = 20 + (k + 1) * p + (w + 1) * 2 * HW;
        check(n >= lo && n <= hi, 1);
        cksel <= c ^ 4'h5;
        sut <= ~s;
        apb(1'b0, `CSS_OFF_STATUS, 32'h0, r, e);
        check(r, {16'h0, 6'h08, exp_src(c), d, s, c});
        apb(1'b0, `CSS_OFF_RANGE, 32'h0, r, e);
        check(r, {29'h0, c[3:1]});
        apb(1'b0, `CSS_OFF_PRESC, 32'h0, r, e);
        check(r, d ? 32'h0 : 32'h3);
        check(presc, d ? 4'h0 : 4'h3);
        apb(1'b1, `CSS_OFF_CTRL, 32'h0000000a, r, e);
        repeat (2) @(posedge pclk);
        check(core_en, 1'b0);
        wake <= 1'b1;
        wait_core(n);
        wake <= 1'b0;
        w = exp_wake(c, s);
        check(n >= (w - 1) * p && n <= (w + 1) * p + 8, 1);
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence: shipped setting, every source code except 8 and 9, sleep modes, unmapped access
    initial begin
        logic [31:0] r;
        logic e, a;
        logic [4:0] g;
        int n;
        boot(4'h2, 2'h2, 1'b0);
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            if (i < 8) boot({1'b1, lfsr[2:1], i[2]}, i[1:0], lfsr[5]);
            else boot(oth[i - 8], lfsr[4:3], lfsr[5]);
        end
        boot(4'h2, 2'h0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            lfsr = next_rand(lfsr);
            a = lfsr[0];
            apb(1'b1, `CSS_OFF_CTRL, {27'h0, a, 1'b1, modes[i]}, r, e);
            repeat (2) @(posedge pclk);
            g = {core_en, fl_en, per_en, conv_en, asy_en};
            check(g, exp_gate(modes[i], a));
            wake <= 1'b1;
            wait_core(n);
            wake <= 1'b0;
            check(n < 40, 1);
            apb(1'b0, `CSS_OFF_CTRL, 32'h0, r, e);
            check(r, {27'h0, a, 1'b0, modes[i]});
        end
        // Software prescaler write reaches the register and the port
        apb(1'b1, `CSS_OFF_PRESC, 32'h00000005, r, e);
        apb(1'b0, `CSS_OFF_PRESC, 32'h0, r, e);
        check(r, 32'h5);
        check(presc, 4'h5);
        apb(1'b0, 12'h010, 32'h0, r, e);
        check(r, 32'h0);
        check(e, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
